// ### rtl/pcs_pin_control.v
// Contract
// - per-pin pullup enable applies to inputs
// - pullup off whenever pin is output
// - pullup off under analog function control, except a3/a2 owned by the converter while i2c is on port a
// - rising-edge keyboard turns pullup into pulldown
// - per-pin slew enable limits transition rate
// - slew enable ignored on input pins
// - per-pin drive select chooses high drive
// - pad bits separate, act per pin
// - highest enabled priority function owns pin
// - comparator inputs outrank others on a1,a0
// - relocate select moves i2c, default a3/a2
// - comparator and converter share analog pin
// - reset: inputs hiz, no pullup except debug pin a4 (and a5 while reset pin enabled)
// - debug pin function on after any reset
// - reset-pin enable sticky until power-on reset
`timescale 1ns/1ps
`default_nettype none
`include "pcs_regs.vh"

module pcs_pin_control #(
  parameter integer NPIN = 8
) (
  // clock and resets
  input wire clk_sys,
  input wire srst,
  input wire por,
  // cpu pad register writes, one strobe per register
  input wire [NPIN-1:0] wr_data,
  input wire pa_pullup_we,
  input wire pb_pullup_we,
  input wire pa_slew_we,
  input wire pb_slew_we,
  input wire pa_drive_we,
  input wire pb_drive_we,
  // system option bits
  input wire opt_we,
  input wire reset_pin_enable_wr,
  input wire debug_pin_enable_wr,
  input wire i2c_pin_relocate_select_wr,
  // parallel io direction, 1 = output
  input wire [NPIN-1:0] pa_dir,
  input wire [NPIN-1:0] pb_dir,
  // peripheral enables
  input wire irq_en,
  input wire timer_clock_input_en,
  input wire cmp_out_en,
  input wire cmp_en,
  input wire spi_en,
  input wire sci_en,
  input wire i2c_en,
  input wire tpm_ch0_en,
  input wire tpm_ch1_en,
  input wire osc_en,
  input wire [7:0] kbd_en,
  input wire [7:0] kbd_rise,
  input wire [7:0] adc_en,
  // peripheral output drive requests per pin
  input wire [NPIN-1:0] pa_periph_oe,
  input wire [NPIN-1:0] pb_periph_oe,
  // pad controls
  output reg [NPIN-1:0] pa_pull_on,
  output reg [NPIN-1:0] pb_pull_on,
  output reg [NPIN-1:0] pa_pull_down,
  output reg [NPIN-1:0] pb_pull_down,
  output reg [NPIN-1:0] pa_slew_on,
  output reg [NPIN-1:0] pb_slew_on,
  output reg [NPIN-1:0] pa_high_drive,
  output reg [NPIN-1:0] pb_high_drive,
  // ownership
  output reg [3*NPIN-1:0] pa_owner,
  output reg [3*NPIN-1:0] pb_owner,
  output reg [NPIN-1:0] pa_analog,
  output reg [NPIN-1:0] pb_analog,
  output reg cmp_adc_shared,
  // option state
  output reg reset_pin_enable,
  output reg debug_pin_enable,
  output reg i2c_pin_relocate_select
);

  // ==========================================================
  // pad control registers
  reg [NPIN-1:0] pin_pullup_enable_bit_a;
  reg [NPIN-1:0] pin_pullup_enable_bit_b;
  reg [NPIN-1:0] pin_slew_enable_bit_a;
  reg [NPIN-1:0] pin_slew_enable_bit_b;
  reg [NPIN-1:0] pin_high_drive_bit_a;
  reg [NPIN-1:0] pin_high_drive_bit_b;

  // port a pad bits; kept apart from port data/direction, each bit acts alone
  always @(posedge clk_sys) begin
    if (srst) begin
      pin_pullup_enable_bit_a <= `PCS_PAD_RST;
      pin_slew_enable_bit_a <= `PCS_PAD_RST;
      pin_high_drive_bit_a <= `PCS_PAD_RST;
    end else begin
      if (pa_pullup_we) pin_pullup_enable_bit_a <= wr_data;
      if (pa_slew_we) pin_slew_enable_bit_a <= wr_data;
      if (pa_drive_we) pin_high_drive_bit_a <= wr_data;
    end
  end

  // port b pad bits; a write to one register never disturbs the others
  always @(posedge clk_sys) begin
    if (srst) begin
      pin_pullup_enable_bit_b <= `PCS_PAD_RST;
      pin_slew_enable_bit_b <= `PCS_PAD_RST;
      pin_high_drive_bit_b <= `PCS_PAD_RST;
    end else begin
      if (pb_pullup_we) pin_pullup_enable_bit_b <= wr_data;
      if (pb_slew_we) pin_slew_enable_bit_b <= wr_data;
      if (pb_drive_we) pin_high_drive_bit_b <= wr_data;
    end
  end

  // ==========================================================
  // system options
  // reset pin enable only clears on power-on, so system reset leaves it
  always @(posedge clk_sys) begin
    if (por) begin
      reset_pin_enable <= 1'b0;
    end else if (opt_we && reset_pin_enable_wr) begin
      reset_pin_enable <= 1'b1;
    end
  end

  always @(posedge clk_sys) begin
    if (srst || por) begin
      debug_pin_enable <= 1'b1;
      i2c_pin_relocate_select <= 1'b0;
    end else if (opt_we) begin
      debug_pin_enable <= debug_pin_enable_wr;
      i2c_pin_relocate_select <= i2c_pin_relocate_select_wr;
    end
  end

  // ==========================================================
  // priority arbitration
  wire i2c_on_a = i2c_en && !i2c_pin_relocate_select;
  wire i2c_on_b = i2c_en && i2c_pin_relocate_select;

  // picks highest enabled level; port is the fallback
  function [2:0] pick;
    input a1;
    input a2;
    input a3;
    input a4;
    begin
      if (a4) pick = `PCS_OWN_ALT4;
      else if (a3) pick = `PCS_OWN_ALT3;
      else if (a2) pick = `PCS_OWN_ALT2;
      else if (a1) pick = `PCS_OWN_ALT1;
      else pick = `PCS_OWN_PORT;
    end
  endfunction

  reg [3*NPIN-1:0] next_pa_owner;
  reg [3*NPIN-1:0] next_pb_owner;
  reg [NPIN-1:0] next_pa_analog;
  reg [NPIN-1:0] next_pb_analog;
  integer i;

  always @* begin
    next_pa_owner = {3*NPIN{1'b0}};
    next_pb_owner = {3*NPIN{1'b0}};
    next_pa_analog = {NPIN{1'b0}};
    next_pb_analog = {NPIN{1'b0}};
    // port a bit 5: irq, timer clock, reset pin
    next_pa_owner[3*5 +: 3] = pick(irq_en, timer_clock_input_en, 1'b0, reset_pin_enable);
    // port a bit 4: debug pin until its enable is cleared
    next_pa_owner[3*4 +: 3] = pick(1'b0, cmp_out_en, 1'b0, debug_pin_enable);
    // port a bits 3/2: keyboard, i2c, converter
    next_pa_owner[3*3 +: 3] = pick(kbd_en[3], i2c_on_a, adc_en[3], 1'b0);
    next_pa_owner[3*2 +: 3] = pick(kbd_en[2], i2c_on_a, adc_en[2], 1'b0);
    // comparator inputs top the list on a1/a0
    next_pa_owner[3*1 +: 3] = pick(kbd_en[1], 1'b0, adc_en[1], cmp_en);
    next_pa_owner[3*0 +: 3] = pick(kbd_en[0], tpm_ch0_en, adc_en[0], cmp_en);
    // converter keeps analog access even if comparator wins ownership
    next_pa_analog[1] = cmp_en || adc_en[1];
    next_pa_analog[0] = cmp_en || adc_en[0];
    next_pa_analog[3] = adc_en[3] && !i2c_on_a;
    next_pa_analog[2] = adc_en[2] && !i2c_on_a;
    // port b: oscillator, relocated i2c, spi/timer
    next_pb_owner[3*7 +: 3] = pick(1'b0, i2c_on_b, osc_en, 1'b0);
    next_pb_owner[3*6 +: 3] = pick(1'b0, i2c_on_b, osc_en, 1'b0);
    next_pb_owner[3*5 +: 3] = pick(1'b0, tpm_ch1_en, spi_en, 1'b0);
    next_pb_owner[3*4 +: 3] = pick(1'b0, spi_en, 1'b0, 1'b0);
    next_pb_analog[7] = osc_en;
    next_pb_analog[6] = osc_en;
    for (i = 0; i < 4; i = i + 1) begin
      // port b low nibble: keyboard, serial, converter on top
      next_pb_owner[3*i +: 3] = pick(kbd_en[4+i], (i >= 2) ? spi_en : sci_en,
                                     adc_en[4+i], 1'b0);
      next_pb_analog[i] = adc_en[4+i];
    end
  end

  // ==========================================================
  // pad drive outputs
  reg [NPIN-1:0] pa_is_out;
  reg [NPIN-1:0] pb_is_out;
  reg [NPIN-1:0] pa_rise;
  reg [NPIN-1:0] pb_rise;
  reg [NPIN-1:0] next_pa_pull;
  reg [NPIN-1:0] next_pb_pull;
  reg [NPIN-1:0] pa_pull_req;

  always @* begin
    pa_is_out = pa_dir | pa_periph_oe;
    pb_is_out = pb_dir | pb_periph_oe;
    pa_rise = {NPIN{1'b0}};
    pb_rise = {NPIN{1'b0}};
    pa_rise[3:0] = kbd_rise[3:0] & kbd_en[3:0];
    pb_rise[3:0] = kbd_rise[7:4] & kbd_en[7:4];
    // reset and debug functions pull up on their own
    pa_pull_req = pin_pullup_enable_bit_a;
    pa_pull_req[5] = pin_pullup_enable_bit_a[5] || reset_pin_enable;
    pa_pull_req[4] = pin_pullup_enable_bit_a[4] || debug_pin_enable;
    // outputs and analog use see no pull device, except a3/a2 under the converter while i2c is on port a
    next_pa_pull = pa_pull_req & ~pa_is_out & ~next_pa_analog;
    next_pb_pull = pin_pullup_enable_bit_b & ~pb_is_out & ~next_pb_analog;
  end

  // pull devices; registered so the pads never see a decode glitch,
  // at the price of one cycle of latency after any enable change
  always @(posedge clk_sys) begin
    if (srst) begin
      pa_pull_on <= {NPIN{1'b0}};
      pb_pull_on <= {NPIN{1'b0}};
      pa_pull_down <= {NPIN{1'b0}};
      pb_pull_down <= {NPIN{1'b0}};
    end else begin
      pa_pull_on <= next_pa_pull;
      pb_pull_on <= next_pb_pull;
      pa_pull_down <= next_pa_pull & pa_rise;
      pb_pull_down <= next_pb_pull & pb_rise;
    end
  end

  // slew and drive only matter while the pin drives; gating them on
  // inputs keeps a stale bit from showing on a listening pad
  always @(posedge clk_sys) begin
    if (srst) begin
      pa_slew_on <= {NPIN{1'b0}};
      pb_slew_on <= {NPIN{1'b0}};
      pa_high_drive <= {NPIN{1'b0}};
      pb_high_drive <= {NPIN{1'b0}};
    end else begin
      pa_slew_on <= pin_slew_enable_bit_a & pa_is_out;
      pb_slew_on <= pin_slew_enable_bit_b & pb_is_out;
      pa_high_drive <= pin_high_drive_bit_a & pa_is_out;
      pb_high_drive <= pin_high_drive_bit_b & pb_is_out;
    end
  end

  // ownership follows the enables with the same latency as the pads,
  // so a pin never shows a new owner with the old pull setting
  always @(posedge clk_sys) begin
    if (srst) begin
      pa_owner <= {3*NPIN{1'b0}};
      pb_owner <= {3*NPIN{1'b0}};
      pa_analog <= {NPIN{1'b0}};
      pb_analog <= {NPIN{1'b0}};
    end else begin
      pa_owner <= next_pa_owner;
      pb_owner <= next_pb_owner;
      pa_analog <= next_pa_analog;
      pb_analog <= next_pb_analog;
    end
  end

  // both analog users on one pin; neither is locked out of it
  always @(posedge clk_sys) begin
    if (srst) begin
      cmp_adc_shared <= 1'b0;
    end else begin
      cmp_adc_shared <= cmp_en && (adc_en[0] || adc_en[1]);
    end
  end

endmodule
`default_nettype wire

// ### rtl/pcs_regs.vh
`ifndef PCS_REGS_VH
`define PCS_REGS_VH
// pad control reset values: everything cleared
`define PCS_PAD_RST 8'h00
// port a bit positions
`define PCS_A_BIT0 0
`define PCS_A_BIT1 1
`define PCS_A_BIT2 2
`define PCS_A_BIT3 3
`define PCS_A_BIT4 4
`define PCS_A_BIT5 5
// port b relocated i2c pins
`define PCS_B_SDA 6
`define PCS_B_SCL 7
// output-only pin (port a bit 5 slot unused for output); slew on by default
`define PCS_OUTONLY_SLEW_RST 1'b1
// function owner codes
`define PCS_OWN_PORT 3'h0
`define PCS_OWN_ALT1 3'h1
`define PCS_OWN_ALT2 3'h2
`define PCS_OWN_ALT3 3'h3
`define PCS_OWN_ALT4 3'h4
`endif

// ### sim/pcs_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// checker on pad and owner outputs
module pcs_chk #(
  parameter integer NPIN = 8
) (
  // clock, resets
  input wire clk_sys,
  input wire srst,
  input wire por,
  // inputs watched
  input wire [NPIN-1:0] pb_dir,
  input wire [NPIN-1:0] pb_periph_oe,
  input wire [7:0] adc_en,
  input wire [7:0] kbd_en,
  input wire [7:0] kbd_rise,
  input wire sci_en,
  input wire cmp_en,
  // outputs watched
  input wire [NPIN-1:0] pb_pull_on,
  input wire [NPIN-1:0] pb_pull_down,
  input wire [NPIN-1:0] pb_slew_on,
  input wire [NPIN-1:0] pb_high_drive,
  input wire [3*NPIN-1:0] pb_owner,
  input wire [3*NPIN-1:0] pa_owner,
  input wire cmp_adc_shared,
  input wire reset_pin_enable
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst || por);
  a_pull_out_off: assert property ((pb_dir[0] || pb_periph_oe[0]) |=> !pb_pull_on[0])
    else $error("pullup on an output pin");
  a_pull_analog_off: assert property (adc_en[4] |=> !pb_pull_on[0])
    else $error("pullup on an analog pin");
  a_pull_turns_down: assert property (pb_pull_on[3] && $past(kbd_en[7] && kbd_rise[7])
    |-> pb_pull_down[3])
    else $error("rising keyboard pull not down");
  a_slew_input_off: assert property (!pb_dir[2] && !pb_periph_oe[2] |=> !pb_slew_on[2])
    else $error("slew on an input pin");
  a_drive_input_off: assert property (!pb_dir[3] && !pb_periph_oe[3] |=> !pb_high_drive[3])
    else $error("high drive on an input pin");
  a_owner_is_adc: assert property (adc_en[4] |=> pb_owner[2:0] == 3'h3)
    else $error("converter does not own pin");
  a_owner_is_port: assert property (!kbd_en[4] && !sci_en && !adc_en[4]
    |=> pb_owner[2:0] == 3'h0)
    else $error("port function lost the idle pin");
  a_cmp_outranks: assert property (cmp_en |=> pa_owner[2:0] == 3'h4)
    else $error("comparator does not own pin");
  a_cmp_adc_share: assert property (cmp_en && adc_en[0] |=> cmp_adc_shared)
    else $error("analog pin not shared");
  a_reset_pin_sticky: assert property (reset_pin_enable |=> reset_pin_enable)
    else $error("reset pin enable cleared");
endmodule
`default_nettype wire
// hookup; the checker cannot see internal state, so it sticks to port relations
bind pcs_pin_control pcs_chk #(.NPIN(NPIN)) u_chk (.clk_sys(clk_sys), .srst(srst), .por(por),
  .pb_dir(pb_dir), .pb_periph_oe(pb_periph_oe), .adc_en(adc_en), .kbd_en(kbd_en),
  .kbd_rise(kbd_rise), .sci_en(sci_en), .cmp_en(cmp_en), .pb_pull_on(pb_pull_on),
  .pb_pull_down(pb_pull_down), .pb_slew_on(pb_slew_on), .pb_high_drive(pb_high_drive),
  .pb_owner(pb_owner), .pa_owner(pa_owner), .cmp_adc_shared(cmp_adc_shared),
  .reset_pin_enable(reset_pin_enable));

// ### sim/pcs_periph_model.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// peripherals that drive shared pins as outputs
module pcs_periph_model (
  // clock
  input wire logic clk_sys,
  // peripheral enables
  input wire logic sci_en,
  input wire logic spi_en,
  input wire logic tpm_ch0_en,
  input wire logic tpm_ch1_en,
  // drive requests
  output logic [7:0] pa_periph_oe,
  output logic [7:0] pb_periph_oe
);
  // transmit, clock, mosi and timer pins become outputs one edge after enable
  always @(posedge clk_sys) begin
    pa_periph_oe <= {7'h00, tpm_ch0_en};
    pb_periph_oe <= {2'h0, tpm_ch1_en, 1'b0, spi_en, spi_en, sci_en, 1'b0};
  end
endmodule
`default_nettype wire

// ### sim/pcs_pin_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// bench
module pcs_pin_control_tb;
  logic clk_sys = 0, srst = 1, por = 1, rst_wr = 0, dbg_wr = 0, rel_wr = 0;
  logic irq_en = 0, timer_clock_input_en = 0, cmp_out_en = 0, cmp_en = 0, spi_en = 0, sci_en = 0;
  logic i2c_en = 0, tpm_ch0_en = 0, tpm_ch1_en = 0, osc_en = 0;
  logic [6:0] we = 0;
  logic [7:0] wr_data = 0, pa_dir = 0, pb_dir = 0, kbd_en = 0, kbd_rise = 0, adc_en = 0;
  wire [7:0] pa_oe, pb_oe, pa_pu, pb_pu, pa_pd, pb_pd, pa_sl, pb_sl, pa_hd, pb_hd, pa_an, pb_an;
  wire [23:0] pa_ow, pb_ow;
  wire shared, rpe, dpe, rel;
  int n_errors = 0, num_checks = 0;
  // 20 MHz
  always #25 clk_sys = ~clk_sys;
  pcs_periph_model u_per (.clk_sys(clk_sys), .sci_en(sci_en), .spi_en(spi_en),
    .tpm_ch0_en(tpm_ch0_en), .tpm_ch1_en(tpm_ch1_en), .pa_periph_oe(pa_oe), .pb_periph_oe(pb_oe));
  pcs_pin_control dut (.clk_sys(clk_sys), .srst(srst), .por(por), .wr_data(wr_data),
    .pa_pullup_we(we[0]), .pb_pullup_we(we[1]), .pa_slew_we(we[2]), .pb_slew_we(we[3]),
    .pa_drive_we(we[4]), .pb_drive_we(we[5]), .opt_we(we[6]), .reset_pin_enable_wr(rst_wr),
    .debug_pin_enable_wr(dbg_wr), .i2c_pin_relocate_select_wr(rel_wr), .pa_dir(pa_dir),
    .pb_dir(pb_dir), .irq_en(irq_en), .timer_clock_input_en(timer_clock_input_en), .cmp_out_en(cmp_out_en),
    .cmp_en(cmp_en), .spi_en(spi_en), .sci_en(sci_en), .i2c_en(i2c_en),
    .tpm_ch0_en(tpm_ch0_en), .tpm_ch1_en(tpm_ch1_en), .osc_en(osc_en), .kbd_en(kbd_en),
    .kbd_rise(kbd_rise), .adc_en(adc_en), .pa_periph_oe(pa_oe), .pb_periph_oe(pb_oe),
    .pa_pull_on(pa_pu), .pb_pull_on(pb_pu), .pa_pull_down(pa_pd), .pb_pull_down(pb_pd),
    .pa_slew_on(pa_sl), .pb_slew_on(pb_sl), .pa_high_drive(pa_hd), .pb_high_drive(pb_hd),
    .pa_owner(pa_ow), .pb_owner(pb_ow), .pa_analog(pa_an), .pb_analog(pb_an),
    .cmp_adc_shared(shared), .reset_pin_enable(rpe), .debug_pin_enable(dpe),
    .i2c_pin_relocate_select(rel));
  // let three edges pass so registered outputs settle
  task st;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  // one-cycle write strobe
  task wr(input int i, input logic [7:0] d);
    @(posedge clk_sys);
    we[i] <= 1'b1;
    wr_data <= d;
    @(posedge clk_sys);
    we[i] <= 1'b0;
  endtask
  task chk(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task close_out;
    $display("checks=%0d mismatches=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // hang guard, tests need about 60 cycles
  initial begin
    #200000;
    n_errors++;
    close_out;
  end
  // main sequence
  initial begin
    repeat (5) @(posedge clk_sys);
    srst <= 0;
    por <= 0;
    st;
    chk({dpe, rpe, rel, pb_pu}, 24'h400);
    chk(pa_ow[17:12], 6'h04);
    chk({pa_hd, pb_sl}, 0);
    $display("end test reset");
    wr(1, 8'hff);
    st;
    chk(pb_pu, 8'hff);
    pb_dir <= 8'h01;
    sci_en <= 1;
    st;
    chk(pb_pu, 8'hfc);
    adc_en <= 8'h40;
    kbd_en <= 8'h80;
    kbd_rise <= 8'h80;
    st;
    chk({pb_pu, pb_pd}, 24'hf808);
    wr(3, 8'hff);
    wr(5, 8'hff);
    st;
    chk({pb_sl, pb_hd, pa_sl}, 24'h030300);
    $display("end test pads");
    // one sharer added per step, lowest first, as software should do
    for (int k = 0; k < 4; k++) begin
      kbd_en[4] <= k >= 1;
      sci_en <= k >= 2;
      adc_en[4] <= k >= 3;
      st;
      chk(pb_ow[2:0], k);
    end
    cmp_en <= 1;
    adc_en[0] <= 1;
    st;
    chk({shared, pa_ow[2:0]}, 4'hc);
    $display("end test owners");
    rst_wr <= 1;
    rel_wr <= 1;
    wr(6, 0);
    st;
    chk({rpe, dpe, rel}, 3'h5);
    rst_wr <= 0;
    wr(6, 0);
    st;
    chk(rpe, 1);
    srst <= 1;
    @(posedge clk_sys);
    srst <= 0;
    st;
    chk({rpe, dpe, rel}, 3'h6);
    por <= 1;
    @(posedge clk_sys);
    por <= 0;
    st;
    chk({rpe, dpe, rel}, 3'h2);
    $display("end test options");
    close_out;
  end
endmodule
`default_nettype wire
